// *** p2p_phy_regs.v ***
// port 2 transceiver control and status registers with standard management aliases
`timescale 1ns/1ps
`include "p2p_map.vh"

// Summary of operation
// [R1] control bit 14 disables the transmitter; resets to zero
// [R2] writing one to control bit 13 restarts negotiation; self-clearing
// [R3] control bit 11 powers the transceiver down; registers keep their settings
// [R4] control bit 10 disables automatic crossover; reset leaves it enabled
// [R5] crossed mode is forced only with automatic crossover off and bit 9 set
// [R6] control bit 8 enables far-end loopback inside this port's transceiver
// [R7] control bit 7 enables negotiation, resets to one; off uses bits 6:5
// [R8] control bit 6 forces 100 Mbps when one, 10 Mbps when zero; resets one
// [R9] control bit 5 forces duplex; also the duplex when negotiation fails
// [R10] software should keep forced duplex zero while negotiation is enabled
// [R11] control bits 4..0 advertise pause and four speed/duplex abilities; reset one
// [R12] status bit 15 is writable, resets one, selects the crossover algorithm
// [R13] status bit 13 reports reversed receive polarity
// [R14] status bits 12 and 11 report transmit and receive flow control activity
// [R15] status bit 10 reports speed, bit 9 reports duplex
// [R16] status bit 7 reports the crossover state, one for crossed
// [R17] status bit 6 shows negotiation done, bit 5 link good; reset zero
// [R18] status bits 4..0 reflect the partner's received abilities
// [R19] the word after the status register is reserved and does nothing
// [R20] aliased bits share storage so both views see every write
// [R21] restart bit clears once the transceiver takes the restart
module p2p_phy_regs #(
    parameter AW = `P2P_ADDR_W
) (
    input  wire          clock,
    input  wire          rst_b,
    input  wire          host_cs,
    input  wire          host_wr,
    input  wire          host_rd,
    input  wire [AW-1:0] host_addr,
    input  wire [1:0]    host_be,
    input  wire [15:0]   host_wdata,
    output reg  [15:0]   host_rdata,
    output reg           host_rvalid,
    input  wire          phy_restart_ack,
    input  wire          phy_polarity_rev,
    input  wire          phy_tx_fc_active,
    input  wire          phy_rx_fc_active,
    input  wire          phy_speed_100,
    input  wire          phy_full_duplex,
    input  wire          phy_mdix_state,
    input  wire          phy_an_done,
    input  wire          phy_link_up,
    input  wire [4:0]    phy_partner_abil,
    output reg           phy_tx_disable,
    output wire          phy_an_restart,
    output reg           phy_power_down,
    output reg           phy_auto_mdix_off,
    output reg           phy_force_mdix,
    output reg           phy_far_loopback,
    output reg           phy_an_enable,
    output reg           phy_force_100,
    output reg           phy_force_full,
    output reg  [4:0]    phy_adv_abil,
    output reg           standard_crossover_select
);

    // ****************************************************************
    // storage
    // ****************************************************************
    reg  [15:0] ctrl_q;
    reg  [15:0] ctrl_d;
    reg         xsel_q;
    reg         xsel_d;
    reg         rst_set;
    wire        an_rst_q;
    wire [15:0] stat_raw;
    wire [15:0] stat_cap;

    // ****************************************************************
    // address decode
    // ****************************************************************
    wire [AW-1:0] word_addr;
    wire          wr_en;
    wire          rd_en;

    assign word_addr = {host_addr[AW-1:1], 1'b0};
    assign wr_en     = host_cs & host_wr;
    assign rd_en     = host_cs & host_rd;

    // ****************************************************************
    // status capture
    // ****************************************************************
    assign stat_raw[15]             = 1'b0;
    assign stat_raw[14]             = 1'b0;
    assign stat_raw[`P2P_ST_POL]    = phy_polarity_rev; // see [R13]
    assign stat_raw[`P2P_ST_TXFC]   = phy_tx_fc_active; // see [R14]
    assign stat_raw[`P2P_ST_RXFC]   = phy_rx_fc_active; // see [R14]
    assign stat_raw[`P2P_ST_SPD]    = phy_speed_100;    // see [R15]
    assign stat_raw[`P2P_ST_DPX]    = phy_full_duplex;  // see [R15]
    assign stat_raw[8]              = 1'b0;
    assign stat_raw[`P2P_ST_MDIX]   = phy_mdix_state;   // see [R16]
    assign stat_raw[`P2P_ST_AND]    = phy_an_done;      // see [R17]
    assign stat_raw[`P2P_ST_LINK]   = phy_link_up;      // see [R17]
    assign stat_raw[4:0]            = phy_partner_abil; // see [R18]

    p2p_stat_cap #(
        .W (16)
    ) u_stat_cap (
        .clock (clock),
        .rst_b (rst_b),
        .raw   (stat_raw),
        .cap_q (stat_cap)
    );

    // ****************************************************************
    // negotiation restart
    // ****************************************************************
    p2p_restart_hs u_restart (
        .clock   (clock),
        .rst_b   (rst_b),
        .set_req (rst_set),
        .ack     (phy_restart_ack),
        .req_q   (an_rst_q)
    );

    // request stays high until taken, so the transceiver cannot miss it
    assign phy_an_restart = an_rst_q; // see [R2]

    // ****************************************************************
    // register views, all built from the same storage
    // ****************************************************************
    wire [15:0] ctrl_view;
    wire [15:0] stat_view;
    reg  [15:0] bcr_view;
    reg  [15:0] anar_view;
    reg  [15:0] bsr_view;
    reg  [15:0] anlp_view;

    assign ctrl_view = {ctrl_q[15:14], an_rst_q, ctrl_q[12:0]};
    assign stat_view = {xsel_q, stat_cap[14:0]}; // see [R12]

    // one storage bit per alias: no copy can drift out of step
    always @* begin
        bcr_view                    = 16'h0000;
        bcr_view[`P2P_BC_TXDIS]     = ctrl_q[`P2P_CTL_TXDIS];   // see [R20]
        bcr_view[`P2P_BC_RSV]       = ctrl_q[12];
        bcr_view[`P2P_BC_MDIXOFF]   = ctrl_q[`P2P_CTL_MDIXOFF];
        bcr_view[`P2P_BC_FMDIX]     = ctrl_q[`P2P_CTL_FMDIX];
        bcr_view[`P2P_BC_XSEL]      = xsel_q;
        bcr_view[`P2P_BC_DPX]       = ctrl_q[`P2P_CTL_DPX];
        bcr_view[`P2P_BC_ANRST]     = an_rst_q;
        bcr_view[`P2P_BC_PDN]       = ctrl_q[`P2P_CTL_PDN];
        bcr_view[`P2P_BC_ANEN]      = ctrl_q[`P2P_CTL_ANEN];
        bcr_view[`P2P_BC_SPD]       = ctrl_q[`P2P_CTL_SPD];
        bcr_view[`P2P_BC_FELB]      = ctrl_q[`P2P_CTL_FELB];
        anar_view                   = 16'h0000;
        anar_view[`P2P_AB_PAUSE]    = ctrl_q[`P2P_CTL_ADV_HI];
        anar_view[`P2P_AB_HI:`P2P_AB_LO] = ctrl_q[3:0];
        bsr_view                    = 16'h0000;
        bsr_view[`P2P_BS_AND]       = stat_cap[`P2P_ST_AND];    // see [R20]
        bsr_view[`P2P_BS_LINK]      = stat_cap[`P2P_ST_LINK];
        anlp_view                   = 16'h0000;
        anlp_view[`P2P_AB_PAUSE]    = stat_cap[4];
        anlp_view[`P2P_AB_HI:`P2P_AB_LO] = stat_cap[3:0];
    end

    // ****************************************************************
    // write path
    // ****************************************************************
    function [15:0] lane_merge;
        input [15:0] cur;
        input [15:0] wd;
        input [1:0]  be;
        begin
            lane_merge[15:8] = be[1] ? wd[15:8] : cur[15:8];
            lane_merge[7:0]  = be[0] ? wd[7:0]  : cur[7:0];
        end
    endfunction

    reg [15:0] m;

    always @* begin
        m       = 16'h0000;
        ctrl_d  = ctrl_q;
        xsel_d  = xsel_q;
        rst_set = 1'b0;
        if (wr_en) begin
            case (word_addr)
                `P2P_CTRL_OFS: begin
                    m       = lane_merge(ctrl_view, host_wdata, host_be);
                    ctrl_d  = {m[15:14], 1'b0, m[12:0]};
                    // writing zero never cancels a pending restart
                    rst_set = host_be[1] & host_wdata[`P2P_CTL_ANRST]; // see [R2]
                end
                `P2P_STAT_OFS: begin
                    m      = lane_merge(stat_view, host_wdata, host_be);
                    xsel_d = m[`P2P_ST_XSEL]; // see [R12]
                end
                `P2P_BCR_MIR_OFS: begin
                    m                          = lane_merge(bcr_view, host_wdata, host_be);
                    ctrl_d[`P2P_CTL_TXDIS]     = m[`P2P_BC_TXDIS];   // see [R20]
                    ctrl_d[12]                 = m[`P2P_BC_RSV];
                    ctrl_d[`P2P_CTL_MDIXOFF]   = m[`P2P_BC_MDIXOFF];
                    ctrl_d[`P2P_CTL_FMDIX]     = m[`P2P_BC_FMDIX];
                    ctrl_d[`P2P_CTL_DPX]       = m[`P2P_BC_DPX];
                    ctrl_d[`P2P_CTL_PDN]       = m[`P2P_BC_PDN];
                    ctrl_d[`P2P_CTL_ANEN]      = m[`P2P_BC_ANEN];
                    ctrl_d[`P2P_CTL_SPD]       = m[`P2P_BC_SPD];
                    ctrl_d[`P2P_CTL_FELB]      = m[`P2P_BC_FELB];
                    xsel_d                     = m[`P2P_BC_XSEL];
                    rst_set = host_be[1] & host_wdata[`P2P_BC_ANRST]; // see [R2]
                end
                `P2P_ANAR_MIR_OFS: begin
                    m                        = lane_merge(anar_view, host_wdata, host_be);
                    ctrl_d[`P2P_CTL_ADV_HI]  = m[`P2P_AB_PAUSE];    // see [R20]
                    ctrl_d[3:0]              = m[`P2P_AB_HI:`P2P_AB_LO];
                end
                // reserved word and read-only views ignore writes
                default: begin
                    m = 16'h0000; // see [R19]
                end
            endcase
        end
    end

    // power down touches no stored setting, so wake-up restores the old mode
    always @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            ctrl_q <= `P2P_CTL_RESET; // see [R7] see [R8] see [R11]
            xsel_q <= `P2P_ST_XSEL_RESET; // see [R12]
        end else begin
            ctrl_q <= ctrl_d; // see [R3]
            xsel_q <= xsel_d;
        end
    end

    // ****************************************************************
    // read path
    // ****************************************************************
    reg [15:0] rd_mux;

    always @* begin
        case (word_addr)
            `P2P_CTRL_OFS:     rd_mux = ctrl_view;
            `P2P_STAT_OFS:     rd_mux = stat_view;
            `P2P_BCR_MIR_OFS:  rd_mux = bcr_view;
            `P2P_ANAR_MIR_OFS: rd_mux = anar_view;
            `P2P_BSR_MIR_OFS:  rd_mux = bsr_view;
            `P2P_ANLP_MIR_OFS: rd_mux = anlp_view;
            default:           rd_mux = 16'h0000; // see [R19]
        endcase
    end

    always @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            host_rdata  <= 16'h0000;
            host_rvalid <= 1'b0;
        end else begin
            host_rvalid <= rd_en;
            if (rd_en) begin
                host_rdata <= rd_mux;
            end
        end
    end

    // ****************************************************************
    // transceiver controls, one flop stage after storage
    // ****************************************************************
    always @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            phy_tx_disable            <= 1'b0;
            phy_power_down            <= 1'b0;
            phy_auto_mdix_off         <= 1'b0;
            phy_force_mdix            <= 1'b0;
            phy_far_loopback          <= 1'b0;
            phy_an_enable             <= 1'b1;
            phy_force_100             <= 1'b1;
            phy_force_full            <= 1'b1;
            phy_adv_abil              <= 5'h1f;
            standard_crossover_select <= `P2P_ST_XSEL_RESET;
        end else begin
            phy_tx_disable    <= ctrl_q[`P2P_CTL_TXDIS];   // see [R1]
            phy_power_down    <= ctrl_q[`P2P_CTL_PDN];     // see [R3]
            phy_auto_mdix_off <= ctrl_q[`P2P_CTL_MDIXOFF]; // see [R4]
            // force bit is meaningless while automatic crossover runs
            phy_force_mdix    <= ctrl_q[`P2P_CTL_MDIXOFF] & ctrl_q[`P2P_CTL_FMDIX]; // see [R5]
            phy_far_loopback  <= ctrl_q[`P2P_CTL_FELB];    // see [R6]
            phy_an_enable     <= ctrl_q[`P2P_CTL_ANEN];    // see [R7]
            phy_force_100     <= ctrl_q[`P2P_CTL_SPD];     // see [R8]
            // also the fallback duplex when negotiation fails
            phy_force_full    <= ctrl_q[`P2P_CTL_DPX];     // see [R9]
            phy_adv_abil      <= ctrl_q[`P2P_CTL_ADV_HI:`P2P_CTL_ADV_LO]; // see [R11]
            standard_crossover_select <= xsel_q;           // see [R12]
        end
    end

endmodule

// *** p2p_map.vh ***
// offsets, field positions and reset values of the port 2 transceiver register pair
`ifndef P2P_MAP_VH
`define P2P_MAP_VH

// ****************************************************************
// host addresses (byte address of each 16-bit word)
// ****************************************************************
`define P2P_ADDR_W          12
`define P2P_CTRL_OFS        12'h096
`define P2P_STAT_OFS        12'h098
`define P2P_RSVD_OFS        12'h09a
`define P2P_BCR_MIR_OFS     12'h0c0
`define P2P_ANAR_MIR_OFS    12'h0c2
`define P2P_BSR_MIR_OFS     12'h0c4
`define P2P_ANLP_MIR_OFS    12'h0c6

// ****************************************************************
// control word fields
// ****************************************************************
`define P2P_CTL_TXDIS       14
`define P2P_CTL_ANRST       13
`define P2P_CTL_PDN         11
`define P2P_CTL_MDIXOFF     10
`define P2P_CTL_FMDIX       9
`define P2P_CTL_FELB        8
`define P2P_CTL_ANEN        7
`define P2P_CTL_SPD         6
`define P2P_CTL_DPX         5
`define P2P_CTL_ADV_HI      4
`define P2P_CTL_ADV_LO      0
`define P2P_CTL_RESET       16'h00ff

// ****************************************************************
// status word fields
// ****************************************************************
`define P2P_ST_XSEL         15
`define P2P_ST_POL          13
`define P2P_ST_TXFC         12
`define P2P_ST_RXFC         11
`define P2P_ST_SPD          10
`define P2P_ST_DPX          9
`define P2P_ST_MDIX         7
`define P2P_ST_AND          6
`define P2P_ST_LINK         5
`define P2P_ST_XSEL_RESET   1'b1

// ****************************************************************
// standard management view fields
// ****************************************************************
`define P2P_BC_TXDIS        1
`define P2P_BC_RSV          2
`define P2P_BC_MDIXOFF      3
`define P2P_BC_FMDIX        4
`define P2P_BC_XSEL         5
`define P2P_BC_DPX          8
`define P2P_BC_ANRST        9
`define P2P_BC_PDN          11
`define P2P_BC_ANEN         12
`define P2P_BC_SPD          13
`define P2P_BC_FELB         14
`define P2P_AB_PAUSE        10
`define P2P_AB_HI           8
`define P2P_AB_LO           5
`define P2P_BS_AND          5
`define P2P_BS_LINK         2

`endif

// *** p2p_restart_hs.v ***
// self-clearing negotiation restart request held until the transceiver takes it
`timescale 1ns/1ps
module p2p_restart_hs (
    input  wire clock,
    input  wire rst_b,
    input  wire set_req,
    input  wire ack,
    output reg  req_q
);
    wire req_d;

    // set wins over a same-cycle acknowledge so a fresh restart is never lost
    assign req_d = set_req | (req_q & ~ack); // see [R2] see [R21]

    always @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            req_q <= 1'b0;
        end else begin
            req_q <= req_d;
        end
    end
endmodule

// *** p2p_stat_cap.v ***
// one register stage per transceiver status bit
`timescale 1ns/1ps
module p2p_stat_cap #(
    parameter W = 16
) (
    input  wire         clock,
    input  wire         rst_b,
    input  wire [W-1:0] raw,
    output wire [W-1:0] cap_q
);
    genvar i;
    generate
        for (i = 0; i < W; i = i + 1) begin : g_bit
            reg bit_q;
            always @(posedge clock or negedge rst_b) begin
                if (!rst_b) begin
                    bit_q <= 1'b0;
                end else begin
                    bit_q <= raw[i];
                end
            end
            assign cap_q[i] = bit_q;
        end
    endgenerate
endmodule

// *** p2p_phy_regs_sva.sv ***
// assertion checker for the port 2 transceiver register pair
`timescale 1ns/1ps
`include "p2p_map.vh"
module p2p_phy_regs_sva #(
    parameter AW = `P2P_ADDR_W
) (
    input wire          clock,
    input wire          rst_b,
    input wire          host_cs,
    input wire          host_wr,
    input wire          host_rd,
    input wire [AW-1:0] host_addr,
    input wire [1:0]    host_be,
    input wire [15:0]   host_wdata,
    input wire [15:0]   host_rdata,
    input wire          host_rvalid,
    input wire          phy_restart_ack,
    input wire          phy_polarity_rev,
    input wire          phy_tx_fc_active,
    input wire          phy_rx_fc_active,
    input wire          phy_speed_100,
    input wire          phy_full_duplex,
    input wire          phy_mdix_state,
    input wire          phy_an_done,
    input wire          phy_link_up,
    input wire [4:0]    phy_partner_abil,
    input wire          phy_tx_disable,
    input wire          phy_an_restart,
    input wire          phy_power_down,
    input wire          phy_auto_mdix_off,
    input wire          phy_force_mdix,
    input wire          phy_far_loopback,
    input wire          phy_an_enable,
    input wire          phy_force_100,
    input wire          phy_force_full,
    input wire [4:0]    phy_adv_abil,
    input wire          standard_crossover_select
);
    // ****************************************************************
    // decodes
    // ****************************************************************
    wire [AW-1:0] wa    = {host_addr[AW-1:1], 1'b0};
    wire          wr    = host_cs && host_wr;
    wire          rd    = host_cs && host_rd;
    wire          ctl_hi = wr && wa == `P2P_CTRL_OFS && host_be[1];
    wire          ctl_lo = wr && wa == `P2P_CTRL_OFS && host_be[0];
    wire          st_hi  = wr && wa == `P2P_STAT_OFS && host_be[1];
    wire          mir_hi = wr && wa == `P2P_BCR_MIR_OFS && host_be[1];
    wire          set_rq = (ctl_hi && host_wdata[13]) || (mir_hi && host_wdata[9]);
    wire          st_rd  = rd && wa == `P2P_STAT_OFS;
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_b);
    // ****************************************************************
    // restart handshake
    // ****************************************************************
    sequence s_restart_set;
        set_rq;
    endsequence
    sequence s_restart_taken;
        phy_an_restart && phy_restart_ack && !set_rq;
    endsequence
    a_restart_set: assert property (s_restart_set |=> phy_an_restart)
        else $error("restart request not raised");
    a_restart_hold: assert property (phy_an_restart && !phy_restart_ack |=>
        phy_an_restart) else $error("restart request dropped early");
    a_restart_clear: assert property (s_restart_taken |=> !phy_an_restart)
        else $error("restart request not cleared");
    // ****************************************************************
    // controls follow writes two edges on; reads lag status by a capture stage
    // ****************************************************************
    a_ctrl_high_byte: assert property (ctl_hi |-> ##2
        {phy_tx_disable, phy_power_down, phy_auto_mdix_off, phy_far_loopback} == $past({
        host_wdata[14], host_wdata[11:10], host_wdata[8]}, 2)) else $error("high byte wrong");
    a_force_mdix_gate: assert property (ctl_hi |-> ##2
        phy_force_mdix == $past(host_wdata[10] && host_wdata[9], 2))
        else $error("forced crossed mode wrong");
    a_forced_mode: assert property (ctl_lo |-> ##2
        {phy_an_enable, phy_force_100, phy_force_full} == $past(host_wdata[7:5], 2))
        else $error("forced mode wrong");
    a_adv_follow: assert property (ctl_lo |-> ##2
        phy_adv_abil == $past(host_wdata[4:0], 2)) else $error("advertised abilities wrong");
    a_xsel_follow: assert property (st_hi |-> ##2
        standard_crossover_select == $past(host_wdata[15], 2)) else $error("select bit wrong");
    a_mirror_alias: assert property (mir_hi |-> ##2 {phy_power_down, phy_an_enable,
        phy_force_100, phy_far_loopback, phy_force_full} == $past({host_wdata[11],
        host_wdata[12], host_wdata[13], host_wdata[14], host_wdata[8]}, 2))
        else $error("mirror write not shared");
    a_status_flags: assert property (st_rd && $past(rst_b) |=>
        host_rdata[13:9] == $past({phy_polarity_rev, phy_tx_fc_active, phy_rx_fc_active,
        phy_speed_100, phy_full_duplex}, 2)) else $error("status flags wrong");
    a_status_link: assert property (st_rd && $past(rst_b) |=>
        host_rdata[7:0] == $past({phy_mdix_state, phy_an_done, phy_link_up,
        phy_partner_abil}, 2)) else $error("link status wrong");
    a_reserved_zero: assert property (rd && wa == `P2P_RSVD_OFS |=>
        host_rdata == 16'h0000) else $error("reserved word not zero");
    a_read_answer: assert property (rd |=> host_rvalid)
        else $error("read not answered");
endmodule
bind p2p_phy_regs p2p_phy_regs_sva #(.AW(AW)) p2p_phy_regs_sva_i (
    .clock(clock), .rst_b(rst_b), .host_cs(host_cs), .host_wr(host_wr), .host_rd(host_rd),
    .host_addr(host_addr), .host_be(host_be), .host_wdata(host_wdata),
    .host_rdata(host_rdata), .host_rvalid(host_rvalid), .phy_restart_ack(phy_restart_ack),
    .phy_polarity_rev(phy_polarity_rev), .phy_tx_fc_active(phy_tx_fc_active),
    .phy_rx_fc_active(phy_rx_fc_active), .phy_speed_100(phy_speed_100),
    .phy_full_duplex(phy_full_duplex), .phy_mdix_state(phy_mdix_state),
    .phy_an_done(phy_an_done), .phy_link_up(phy_link_up), .phy_partner_abil(phy_partner_abil),
    .phy_tx_disable(phy_tx_disable), .phy_an_restart(phy_an_restart),
    .phy_power_down(phy_power_down), .phy_auto_mdix_off(phy_auto_mdix_off),
    .phy_force_mdix(phy_force_mdix), .phy_far_loopback(phy_far_loopback),
    .phy_an_enable(phy_an_enable), .phy_force_100(phy_force_100),
    .phy_force_full(phy_force_full), .phy_adv_abil(phy_adv_abil),
    .standard_crossover_select(standard_crossover_select));

// *** test_p2p_phy_regs.sv ***
// self-checking bench for the port 2 transceiver register pair
`timescale 1ns/1ps
`include "p2p_map.vh"
module test_p2p_phy_regs;
    reg         clock, rst_b, host_cs, host_wr, host_rd, phy_restart_ack;
    reg  [11:0] host_addr;
    reg  [1:0]  host_be;
    reg  [15:0] host_wdata;
    reg  [12:0] st_in;
    wire [15:0] host_rdata;
    wire        host_rvalid, phy_an_restart, xsel;
    wire [15:0] pins;
    wire        p_tx, p_pd, p_mo, p_fm, p_lb, p_an, p_f100, p_ff;
    wire [4:0]  p_adv;
    integer     bad_count, cmp_count, i;
    reg  [15:0] row_wd [0:6];
    reg  [15:0] row_pin [0:6];
    reg  [12:0] row_st [0:3];
    reg  [15:0] row_sr [0:3];
    assign pins = {3'b000, p_tx, p_pd, p_mo, p_fm, p_lb, p_an, p_f100, p_ff, p_adv};
    p2p_phy_regs #(.AW(12)) p2p_phy_regs_i (
        .clock(clock), .rst_b(rst_b), .host_cs(host_cs), .host_wr(host_wr),
        .host_rd(host_rd), .host_addr(host_addr), .host_be(host_be),
        .host_wdata(host_wdata), .host_rdata(host_rdata), .host_rvalid(host_rvalid),
        .phy_restart_ack(phy_restart_ack), .phy_polarity_rev(st_in[12]),
        .phy_tx_fc_active(st_in[11]), .phy_rx_fc_active(st_in[10]),
        .phy_speed_100(st_in[9]), .phy_full_duplex(st_in[8]), .phy_mdix_state(st_in[7]),
        .phy_an_done(st_in[6]), .phy_link_up(st_in[5]), .phy_partner_abil(st_in[4:0]),
        .phy_tx_disable(p_tx), .phy_an_restart(phy_an_restart), .phy_power_down(p_pd),
        .phy_auto_mdix_off(p_mo), .phy_force_mdix(p_fm), .phy_far_loopback(p_lb),
        .phy_an_enable(p_an), .phy_force_100(p_f100), .phy_force_full(p_ff),
        .phy_adv_abil(p_adv), .standard_crossover_select(xsel));
    // ****************************************************************
    // helpers
    // ****************************************************************
    task finish_test;
        $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task chk(input string nm, input [15:0] e, input [15:0] g);
        cmp_count = cmp_count + 1;
        if (g !== e) begin
            $display("BAD %s expected %h seen %h", nm, e, g);
            bad_count = bad_count + 1;
        end
    endtask
    task wr_reg(input [11:0] a, input [1:0] be, input [15:0] d);
        @(negedge clock);
        {host_cs, host_wr, host_addr, host_be, host_wdata} = {2'b11, a, be, d};
        @(negedge clock);
        {host_cs, host_wr} = 2'b00;
    endtask
    // rvalid lasts one cycle, so it is polled at every falling edge
    task rd_chk(input [11:0] a, input [15:0] e, input string nm);
        integer n;
        @(negedge clock);
        {host_cs, host_rd, host_addr} = {2'b11, a};
        @(negedge clock);
        {host_cs, host_rd} = 2'b00;
        n = 0;
        while (host_rvalid !== 1'b1 && n < 4) begin
            @(negedge clock);
            n = n + 1;
        end
        if (host_rvalid !== 1'b1) begin
            bad_count = bad_count + 1;
            finish_test;
        end else
            chk(nm, e, host_rdata);
    endtask
    task ack_pulse;
        @(negedge clock);
        phy_restart_ack = 1'b1;
        @(negedge clock);
        phy_restart_ack = 1'b0;
    endtask
    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end
    // ****************************************************************
    // main sequence
    // ****************************************************************
    initial begin
        {rst_b, host_cs, host_wr, host_rd, phy_restart_ack} = 5'b00000;
        {host_addr, host_be, host_wdata, st_in} = 0;
        {bad_count, cmp_count} = 0;
        row_wd  = '{16'h4000, 16'h0e00, 16'h0200, 16'h0100, 16'h085a, 16'h9020, 16'h00df};
        row_pin = '{16'h1000, 16'h0e00, 16'h0000, 16'h0100, 16'h085a, 16'h0020, 16'h00df};
        row_st  = '{13'h1555, 13'h0aaa, 13'h1fff, 13'h0000};
        row_sr  = '{16'haa55, 16'h94aa, 16'hbeff, 16'h8000};
        repeat (16) @(posedge clock);
        @(negedge clock);
        rst_b = 1'b1;
        chk("pins", 16'h00ff, pins);
        chk("xsel", 16'h0001, {15'h0000, xsel});
        rd_chk(`P2P_CTRL_OFS, 16'h00ff, "ctrl");
        rd_chk(`P2P_STAT_OFS, 16'h8000, "stat");
        for (i = 0; i < 7; i = i + 1) begin
            wr_reg(`P2P_CTRL_OFS, 2'b11, row_wd[i]);
            @(negedge clock);
            chk("pins", row_pin[i], pins);
            rd_chk(`P2P_CTRL_OFS, row_wd[i], "ctrl");
        end
        for (i = 0; i < 4; i = i + 1) begin
            @(negedge clock);
            st_in = row_st[i];
            rd_chk(`P2P_STAT_OFS, row_sr[i], "stat");
        end
        // read-only status bits must shrug off a full write
        wr_reg(`P2P_STAT_OFS, 2'b11, 16'h7fff);
        rd_chk(`P2P_STAT_OFS, 16'h0000, "stat");
        chk("xsel", 16'h0000, {15'h0000, xsel});
        wr_reg(`P2P_STAT_OFS, 2'b11, 16'h8000);
        // restart needs the high byte enabled
        wr_reg(`P2P_CTRL_OFS, 2'b01, 16'h2000);
        @(negedge clock);
        chk("restart", 16'h0000, {15'h0000, phy_an_restart});
        wr_reg(`P2P_CTRL_OFS, 2'b11, 16'h2000);
        rd_chk(`P2P_CTRL_OFS, 16'h2000, "ctrl");
        repeat (3) @(negedge clock);
        chk("restart", 16'h0001, {15'h0000, phy_an_restart});
        ack_pulse;
        chk("restart", 16'h0000, {15'h0000, phy_an_restart});
        rd_chk(`P2P_CTRL_OFS, 16'h0000, "ctrl");
        wr_reg(`P2P_RSVD_OFS, 2'b11, 16'hffff);
        rd_chk(`P2P_RSVD_OFS, 16'h0000, "rsvd");
        rd_chk(`P2P_CTRL_OFS, 16'h0000, "ctrl");
        // both views share one store
        wr_reg(`P2P_BCR_MIR_OFS, 2'b11, 16'h4802);
        rd_chk(`P2P_CTRL_OFS, 16'h4900, "ctrl");
        wr_reg(`P2P_ANAR_MIR_OFS, 2'b11, 16'h0560);
        rd_chk(`P2P_CTRL_OFS, 16'h491b, "ctrl");
        rd_chk(`P2P_BCR_MIR_OFS, 16'h4802, "bcr");
        rd_chk(`P2P_ANAR_MIR_OFS, 16'h0560, "anar");
        rd_chk(`P2P_STAT_OFS, 16'h0000, "stat");
        wr_reg(`P2P_BCR_MIR_OFS, 2'b10, 16'h0200);
        @(negedge clock);
        chk("restart", 16'h0001, {15'h0000, phy_an_restart});
        ack_pulse;
        chk("restart", 16'h0000, {15'h0000, phy_an_restart});
        finish_test;
    end
endmodule
